// ===== inc/timer_consts.svh
// Register offsets, field positions, reset values and timing counts for the timer block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_BASIC_CTRL 8'h88
`define ADDR_BASIC_MODE 8'h89
`define ADDR_T0_LOW 8'h8a
`define ADDR_T1_LOW 8'h8b
`define ADDR_T0_HIGH 8'h8c
`define ADDR_T1_HIGH 8'h8d
`define ADDR_CLK_RATE 8'h8e
`define ADDR_T2_CTRL 8'hc8
`define ADDR_T2_CAP_LOW 8'hca
`define ADDR_T2_CAP_HIGH 8'hcb
`define ADDR_T2_LOW 8'hcc
`define ADDR_T2_HIGH 8'hcd
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BC_TF1 7
`define BC_TR1 6
`define BC_TF0 5
`define BC_TR0 4
`define BM_T0_CT 2
`define BM_T1_CT 6
`define CR_T0_RATE 3
`define CR_T1_RATE 4
`define CR_T2_RATE 5
`define T2C_TF2 7
`define T2C_THIRD_TIMER_EXTERNAL_FLAG 6
`define T2C_RCLK 5
`define T2C_RESERVED_TX_CLOCK_SELECT 4
`define T2C_THIRD_TIMER_EXTERNAL_ENABLE 3
`define T2C_TR2 2
`define T2C_CT2 1
`define T2C_CPRL 0
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define PRESCALE_LAST 4'hb
`endif

// ===== inc/timer_pkg.sv
// Types shared by the timer block
package timer_pkg;
   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } basic_mode_t;
endpackage

// ===== rtl/timer01_modes_and_timer2.sv
// Two basic timers with four modes plus a third 16-bit capture/reload timer
`include "timer_consts.svh"
module timer01_modes_and_timer2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic timer0_count_pin_i,
   input wire logic timer1_count_pin_i,
   input wire logic third_timer_count_pin_i,
   input wire logic trigger_pin_i,
   input wire logic timer0_vector_i,
   input wire logic timer1_vector_i,
   output logic timer0_overflow_flag_o,
   output logic timer1_overflow_flag_o,
   output logic third_timer_overflow_flag_o,
   output logic third_timer_external_flag_o,
   output logic timer1_overflow_pulse_o
);
   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   function automatic logic wr_hit(input logic [7:0] a);
      return sfr_wr_i && (sfr_addr_i == a);
   endfunction

   // Next {high, low} of a basic timer on one count step
   function automatic logic [15:0] basic_next(input timer_pkg::basic_mode_t m, input logic [7:0] tl,
                                              input logic [7:0] th);
      logic [12:0] c13;
      c13 = 13'({th, tl[4:0]} + 13'h0001);
      case (m)
         timer_pkg::MODE_13BIT: basic_next = {c13[12:5], tl[7:5], c13[4:0]};
         timer_pkg::MODE_16BIT: basic_next = 16'({th, tl} + 16'h0001);
         timer_pkg::MODE_RELOAD: basic_next = {th, (tl == 8'hff) ? th : 8'(tl + 8'h01)};
         default: basic_next = {th, 8'(tl + 8'h01)};
      endcase
   endfunction

   function automatic logic basic_ovf(input timer_pkg::basic_mode_t m, input logic [7:0] tl,
                                      input logic [7:0] th);
      case (m)
         timer_pkg::MODE_13BIT: basic_ovf = (tl[4:0] == 5'h1f) && (th == 8'hff);
         timer_pkg::MODE_16BIT: basic_ovf = (tl == 8'hff) && (th == 8'hff);
         default: basic_ovf = (tl == 8'hff);
      endcase
   endfunction

   // ----------------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------------------
   // Bit order: 0 timer0 pin, 1 timer1 pin, 2 third timer count pin, 3 trigger pin
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [3:0] pin_prev;
   logic [3:0] pin_fall;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= 4'hf;
         pin_sync <= 4'hf;
         pin_prev <= 4'hf;
      end else begin
         pin_meta <= {trigger_pin_i, third_timer_count_pin_i, timer1_count_pin_i, timer0_count_pin_i};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end
   assign pin_fall = pin_prev & ~pin_sync;

   // Divide-by-12 timebase, free running so all timers share one phase
   logic [3:0] presc;
   logic tick12;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc <= 4'h0;
      end else begin
         presc <= (presc == `PRESCALE_LAST) ? 4'h0 : 4'(presc + 4'h1);
      end
   end
   assign tick12 = (presc == `PRESCALE_LAST);

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------
   logic [7:0] basic_timer_mode_register;
   logic [7:0] clock_rate_control;
   logic [3:0] basic_ctrl_low;
   logic timer0_run;
   logic timer1_run;
   logic reserved_rx_clock_select;
   logic reserved_tx_clock_select;
   logic third_timer_external_enable;
   logic third_timer_run;
   logic third_timer_counter_select;
   logic capture_reload_select;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         basic_timer_mode_register <= `RST_BYTE;
         clock_rate_control <= `RST_BYTE;
         basic_ctrl_low <= 4'h0;
         timer0_run <= 1'b0;
         timer1_run <= 1'b0;
         reserved_rx_clock_select <= 1'b0;
         reserved_tx_clock_select <= 1'b0;
         third_timer_external_enable <= 1'b0;
         third_timer_run <= 1'b0;
         third_timer_counter_select <= 1'b0;
         capture_reload_select <= 1'b0;
      end else begin
         if (wr_hit(`ADDR_BASIC_MODE)) begin
            basic_timer_mode_register <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_CLK_RATE)) begin
            clock_rate_control <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_BASIC_CTRL)) begin
            basic_ctrl_low <= sfr_wdata_i[3:0];
            timer0_run <= sfr_wdata_i[`BC_TR0];
            timer1_run <= sfr_wdata_i[`BC_TR1];
         end
         if (wr_hit(`ADDR_T2_CTRL)) begin
            reserved_rx_clock_select <= sfr_wdata_i[`T2C_RCLK];
            reserved_tx_clock_select <= sfr_wdata_i[`T2C_RESERVED_TX_CLOCK_SELECT];
            third_timer_external_enable <= sfr_wdata_i[`T2C_THIRD_TIMER_EXTERNAL_ENABLE];
            third_timer_run <= sfr_wdata_i[`T2C_TR2];
            third_timer_counter_select <= sfr_wdata_i[`T2C_CT2];
            capture_reload_select <= sfr_wdata_i[`T2C_CPRL];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Basic timers
   // ----------------------------------------------------------------------------
   timer_pkg::basic_mode_t mode0;
   timer_pkg::basic_mode_t mode1;
   logic [7:0] timer0_low_byte;
   logic [7:0] timer0_high_byte;
   logic [7:0] timer1_low_byte;
   logic [7:0] timer1_high_byte;
   logic [15:0] next_t0;
   logic [15:0] next_t1;
   logic split0;
   logic src0;
   logic src1;
   logic inc0;
   logic inc1;
   logic inc_th0;
   logic ov0;
   logic ov1;
   logic ov_th0;
   assign mode0 = timer_pkg::basic_mode_t'(basic_timer_mode_register[1:0]);
   assign mode1 = timer_pkg::basic_mode_t'(basic_timer_mode_register[5:4]);
   assign split0 = (mode0 == timer_pkg::MODE_SPLIT);
   assign src0 = basic_timer_mode_register[`BM_T0_CT] ? pin_fall[0] : (clock_rate_control[`CR_T0_RATE] | tick12);
   assign src1 = basic_timer_mode_register[`BM_T1_CT] ? pin_fall[1] : (clock_rate_control[`CR_T1_RATE] | tick12);
   assign inc0 = timer0_run && src0;
   // Timer1 loses its run bit to the split high byte, so it free-runs meanwhile unless its own mode is split
   assign inc1 = (split0 || timer1_run) && src1 && (mode1 != timer_pkg::MODE_SPLIT);
   // The split high byte only counts clocks, never its pin
   assign inc_th0 = split0 && timer1_run && (clock_rate_control[`CR_T0_RATE] | tick12);
   assign next_t0 = basic_next(mode0, timer0_low_byte, timer0_high_byte);
   assign next_t1 = basic_next(mode1, timer1_low_byte, timer1_high_byte);
   assign ov0 = inc0 && basic_ovf(mode0, timer0_low_byte, timer0_high_byte);
   assign ov1 = inc1 && basic_ovf(mode1, timer1_low_byte, timer1_high_byte);
   assign ov_th0 = inc_th0 && (timer0_high_byte == 8'hff);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer0_low_byte <= `RST_BYTE;
         timer0_high_byte <= `RST_BYTE;
      end else begin
         if (inc0) begin
            timer0_low_byte <= next_t0[7:0];
            if (!split0) begin
               timer0_high_byte <= next_t0[15:8];
            end
         end
         if (inc_th0) begin
            timer0_high_byte <= 8'(timer0_high_byte + 8'h01);
         end
         if (wr_hit(`ADDR_T0_LOW)) begin
            timer0_low_byte <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_T0_HIGH)) begin
            timer0_high_byte <= sfr_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer1_low_byte <= `RST_BYTE;
         timer1_high_byte <= `RST_BYTE;
      end else begin
         if (inc1) begin
            {timer1_high_byte, timer1_low_byte} <= next_t1;
         end
         if (wr_hit(`ADDR_T1_LOW)) begin
            timer1_low_byte <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_T1_HIGH)) begin
            timer1_high_byte <= sfr_wdata_i;
         end
      end
   end

   // Flags: a hardware set in the same cycle beats a vector or software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer0_overflow_flag_o <= 1'b0;
         timer1_overflow_flag_o <= 1'b0;
         timer1_overflow_pulse_o <= 1'b0;
      end else begin
         timer1_overflow_pulse_o <= ov1;
         if (ov0) begin
            timer0_overflow_flag_o <= 1'b1;
         end else if (timer0_vector_i) begin
            timer0_overflow_flag_o <= 1'b0;
         end else if (wr_hit(`ADDR_BASIC_CTRL)) begin
            timer0_overflow_flag_o <= sfr_wdata_i[`BC_TF0];
         end
         if (split0 ? ov_th0 : ov1) begin
            timer1_overflow_flag_o <= 1'b1;
         end else if (timer1_vector_i) begin
            timer1_overflow_flag_o <= 1'b0;
         end else if (wr_hit(`ADDR_BASIC_CTRL)) begin
            timer1_overflow_flag_o <= sfr_wdata_i[`BC_TF1];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Third timer
   // ----------------------------------------------------------------------------
   logic [7:0] third_timer_low_byte;
   logic [7:0] third_timer_high_byte;
   logic [7:0] capture_reload_low;
   logic [7:0] capture_reload_high;
   logic reserved2;
   logic cap_mode;
   logic inc2;
   logic ovf2;
   logic trig;
   logic trig_cap;
   logic trig_reload;
   assign reserved2 = reserved_rx_clock_select | reserved_tx_clock_select;
   assign cap_mode = capture_reload_select && !reserved2;
   assign inc2 = third_timer_run && (third_timer_counter_select ? pin_fall[2] :
                 (clock_rate_control[`CR_T2_RATE] | tick12));
   assign ovf2 = inc2 && ({third_timer_high_byte, third_timer_low_byte} == 16'hffff);
   assign trig = third_timer_external_enable && pin_fall[3];
   assign trig_cap = trig && cap_mode;
   assign trig_reload = trig && !capture_reload_select && !reserved2;

   // Reload uses whatever software left in the reload bytes; reset leaves zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {third_timer_high_byte, third_timer_low_byte} <= `RST_WORD;
      end else begin
         if ((ovf2 && !cap_mode) || trig_reload) begin
            {third_timer_high_byte, third_timer_low_byte} <= {capture_reload_high, capture_reload_low};
         end else if (inc2) begin
            {third_timer_high_byte, third_timer_low_byte} <= 16'({third_timer_high_byte, third_timer_low_byte} + 16'h0001);
         end
         if (wr_hit(`ADDR_T2_LOW)) begin
            third_timer_low_byte <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_T2_HIGH)) begin
            third_timer_high_byte <= sfr_wdata_i;
         end
      end
   end

   // A capture event beats a software write to the same bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {capture_reload_high, capture_reload_low} <= `RST_WORD;
      end else begin
         if (wr_hit(`ADDR_T2_CAP_LOW)) begin
            capture_reload_low <= sfr_wdata_i;
         end
         if (wr_hit(`ADDR_T2_CAP_HIGH)) begin
            capture_reload_high <= sfr_wdata_i;
         end
         if (trig_cap) begin
            {capture_reload_high, capture_reload_low} <= {third_timer_high_byte, third_timer_low_byte};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         third_timer_overflow_flag_o <= 1'b0;
         third_timer_external_flag_o <= 1'b0;
      end else begin
         if (ovf2 && !reserved2) begin
            third_timer_overflow_flag_o <= 1'b1;
         end else if (wr_hit(`ADDR_T2_CTRL)) begin
            third_timer_overflow_flag_o <= sfr_wdata_i[`T2C_TF2];
         end
         if (trig) begin
            third_timer_external_flag_o <= 1'b1;
         end else if (wr_hit(`ADDR_T2_CTRL)) begin
            third_timer_external_flag_o <= sfr_wdata_i[`T2C_THIRD_TIMER_EXTERNAL_FLAG];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= `RST_BYTE;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == `ADDR_BASIC_CTRL) begin
            sfr_rdata_o <= {timer1_overflow_flag_o, timer1_run, timer0_overflow_flag_o, timer0_run, basic_ctrl_low};
         end else if (sfr_addr_i == `ADDR_BASIC_MODE) begin
            sfr_rdata_o <= basic_timer_mode_register;
         end else if (sfr_addr_i == `ADDR_T0_LOW) begin
            sfr_rdata_o <= timer0_low_byte;
         end else if (sfr_addr_i == `ADDR_T1_LOW) begin
            sfr_rdata_o <= timer1_low_byte;
         end else if (sfr_addr_i == `ADDR_T0_HIGH) begin
            sfr_rdata_o <= timer0_high_byte;
         end else if (sfr_addr_i == `ADDR_T1_HIGH) begin
            sfr_rdata_o <= timer1_high_byte;
         end else if (sfr_addr_i == `ADDR_CLK_RATE) begin
            sfr_rdata_o <= clock_rate_control;
         end else if (sfr_addr_i == `ADDR_T2_CTRL) begin
            sfr_rdata_o <= {third_timer_overflow_flag_o, third_timer_external_flag_o, reserved_rx_clock_select,
                            reserved_tx_clock_select, third_timer_external_enable, third_timer_run,
                            third_timer_counter_select, capture_reload_select};
         end else if (sfr_addr_i == `ADDR_T2_CAP_LOW) begin
            sfr_rdata_o <= capture_reload_low;
         end else if (sfr_addr_i == `ADDR_T2_CAP_HIGH) begin
            sfr_rdata_o <= capture_reload_high;
         end else if (sfr_addr_i == `ADDR_T2_LOW) begin
            sfr_rdata_o <= third_timer_low_byte;
         end else if (sfr_addr_i == `ADDR_T2_HIGH) begin
            sfr_rdata_o <= third_timer_high_byte;
         end else begin
            sfr_rdata_o <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   low_wrap_a: assert property ((mode0 == timer_pkg::MODE_16BIT) && inc0 && (timer0_low_byte == 8'hff) && !sfr_wr_i
      |=> (timer0_low_byte == 8'h00) && (timer0_high_byte == 8'($past(timer0_high_byte) + 8'h01)))
      else $error("low byte wrap did not carry");
   full_wrap_a: assert property ((mode1 == timer_pkg::MODE_16BIT) && ov1 && !sfr_wr_i
      |=> ({timer1_high_byte, timer1_low_byte} == 16'h0000) ##1 timer1_overflow_pulse_o == 1'b0)
      else $error("16-bit count did not wrap to zero");
   byte_reload_a: assert property ((mode0 == timer_pkg::MODE_RELOAD) && inc0 && (timer0_low_byte == 8'hff) && !sfr_wr_i
      |=> (timer0_low_byte == $past(timer0_high_byte)) && timer0_overflow_flag_o)
      else $error("reload mode did not load high byte");
   split_high_a: assert property (ov_th0 |=> timer1_overflow_flag_o && (timer0_high_byte == 8'h00))
      else $error("split high byte overflow not flagged");
   t1_hold_a: assert property ((mode1 == timer_pkg::MODE_SPLIT) && !sfr_wr_i
      |=> $stable(timer1_low_byte) && $stable(timer1_high_byte))
      else $error("timer1 moved in split mode");
   t2_stop_a: assert property (!third_timer_run && !sfr_wr_i && !trig
      |=> $stable({third_timer_high_byte, third_timer_low_byte}))
      else $error("third timer counted while stopped");
   t2_capture_a: assert property (trig_cap |=> ({capture_reload_high, capture_reload_low} ==
      $past({third_timer_high_byte, third_timer_low_byte})) && third_timer_external_flag_o)
      else $error("capture did not copy count");
   t2_reload_a: assert property (ovf2 && !cap_mode && !sfr_wr_i
      |=> ({third_timer_high_byte, third_timer_low_byte} == $past({capture_reload_high, capture_reload_low}))
      && (third_timer_overflow_flag_o == !$past(reserved2) || $past(third_timer_overflow_flag_o)))
      else $error("overflow reload wrong");
   ext_ignore_a: assert property (!third_timer_external_enable && !sfr_wr_i |=> !$rose(third_timer_external_flag_o))
      else $error("external flag set while disabled");
   vec_clear_a: assert property (timer0_vector_i && !ov0 |=> !timer0_overflow_flag_o)
      else $error("vector did not clear flag");

   capture_seen_c: cover property (trig_cap);
   reload_seen_c: cover property (ovf2 && !cap_mode);
   split_seen_c: cover property (ov_th0 ##1 timer1_overflow_flag_o);
endmodule

// ===== dv/core_model.sv
// Processor core model: register accesses and handler vector pulses
module core_model (
   input wire logic clk_i,
   input wire logic [7:0] sfr_rdata_i,
   output logic [7:0] sfr_addr_o,
   output logic sfr_wr_o,
   output logic sfr_rd_o,
   output logic [7:0] sfr_wdata_o,
   output logic timer0_vector_o,
   output logic timer1_vector_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   initial begin
      sfr_addr_o = 8'h00;
      sfr_wr_o = 1'b0;
      sfr_rd_o = 1'b0;
      sfr_wdata_o = 8'h00;
      timer0_vector_o = 1'b0;
      timer1_vector_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_o <= a;
      sfr_wdata_o <= d;
      sfr_wr_o <= 1'b1;
      @(posedge clk_i);
      sfr_wr_o <= 1'b0;
      // Released data is inverted so no stale value looks valid
      sfr_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_o <= a;
      sfr_rd_o <= 1'b1;
      @(posedge clk_i);
      sfr_rd_o <= 1'b0;
      @(posedge clk_i);
      d = sfr_rdata_i;
   endtask
   // One-cycle vector pulse as the core enters a handler
   task automatic vec(input bit t1);
      @(posedge clk_i);
      if (t1) begin
         timer1_vector_o <= 1'b1;
      end else begin
         timer0_vector_o <= 1'b1;
      end
      @(posedge clk_i);
      timer0_vector_o <= 1'b0;
      timer1_vector_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

// ===== dv/tb_timer01_modes_and_timer2.sv
// Self-checking bench for the timer block
`include "timer_consts.svh"
module tb_timer01_modes_and_timer2;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, trig, t2pin, sfr_wr, sfr_rd, vec0, vec1, tf0, tf1, tf2, third_timer_external_flag;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
   int bad_count, n_checks;
   logic t1pulse;
   int n_pulse;
   timer01_modes_and_timer2 timer01_modes_and_timer2_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr),
      .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
      .timer0_count_pin_i(1'b1), .timer1_count_pin_i(1'b1), .third_timer_count_pin_i(t2pin),
      .trigger_pin_i(trig), .timer0_vector_i(vec0), .timer1_vector_i(vec1), .timer0_overflow_flag_o(tf0),
      .timer1_overflow_flag_o(tf1), .third_timer_overflow_flag_o(tf2), .third_timer_external_flag_o(third_timer_external_flag),
      .timer1_overflow_pulse_o(t1pulse));
   core_model core_model_i (.clk_i(clk_i), .sfr_rdata_i(sfr_rdata), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
      .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .timer0_vector_o(vec0), .timer1_vector_o(vec1));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Return past the landing edge so flag checks see its result, not a race
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      core_model_i.wr(a, d);
      @(negedge clk_i);
   endtask
   // The overflow pulse is one cycle wide, so count it between edges
   always @(negedge clk_i) begin
      if (t1pulse === 1'b1) begin
         n_pulse++;
      end
   end
   // Pulses held 4 clocks each so the two-flop sync sees every level
   task automatic pulses(input bit cnt, input int n);
      repeat (n) begin
         @(posedge clk_i);
         if (cnt) t2pin <= 1'b0; else trig <= 1'b0;
         repeat (4) @(posedge clk_i);
         t2pin <= 1'b1;
         trig <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic basic_modes;
      wr(`ADDR_CLK_RATE, 8'h38);
      wr(`ADDR_BASIC_MODE, 8'h01);
      wr(`ADDR_T0_LOW, 8'hff);
      wr(`ADDR_T0_HIGH, 8'hff);
      wr(`ADDR_BASIC_CTRL, 8'h10);
      @(negedge clk_i);
      check("tf0 wrap", tf0, 8'h01);
      // Stop with the flag bit written as one, so the vector clear is what is seen
      wr(`ADDR_BASIC_CTRL, 8'h20);
      core_model_i.rd(`ADDR_T0_HIGH, v);
      check("t0 high wrap", v, 8'h00);
      core_model_i.vec(1'b0);
      check("tf0 vector", tf0, 8'h00);
      wr(`ADDR_BASIC_MODE, 8'h02);
      wr(`ADDR_T0_HIGH, 8'hc8);
      wr(`ADDR_T0_LOW, 8'hff);
      wr(`ADDR_BASIC_CTRL, 8'h10);
      wr(`ADDR_BASIC_CTRL, 8'h00);
      core_model_i.rd(`ADDR_T0_LOW, v);
      check("t0 low reload", v, 8'hc9);
      core_model_i.rd(`ADDR_T0_HIGH, v);
      check("t0 high hold", v, 8'hc8);
      $display("basic modes done");
   endtask
   task automatic split_mode;
      core_model_i.vec(1'b0);
      wr(`ADDR_BASIC_MODE, 8'h33);
      wr(`ADDR_T1_LOW, 8'h55);
      wr(`ADDR_T0_LOW, 8'hff);
      wr(`ADDR_T0_HIGH, 8'hff);
      wr(`ADDR_BASIC_CTRL, 8'h50);
      @(negedge clk_i);
      check("tf0 split", tf0, 8'h01);
      check("tf1 split", tf1, 8'h01);
      wr(`ADDR_BASIC_CTRL, 8'ha0);
      core_model_i.rd(`ADDR_T1_LOW, v);
      check("t1 held", v, 8'h55);
      core_model_i.vec(1'b1);
      check("tf1 vector", tf1, 8'h00);
      // Timer1 runs without its run bit while timer0 is split, and raises no flag
      wr(`ADDR_T1_LOW, 8'hff);
      wr(`ADDR_T1_HIGH, 8'hff);
      v = 8'(n_pulse);
      wr(`ADDR_BASIC_MODE, 8'h13);
      wr(`ADDR_BASIC_MODE, 8'h33);
      check("t1 pulses", 8'(n_pulse) - v, 8'h01);
      check("tf1 no flag", tf1, 8'h00);
      core_model_i.rd(`ADDR_T1_LOW, v);
      check("t1 counted", v, 8'h01);
      $display("split mode done");
   endtask
   task automatic t2_reload;
      wr(`ADDR_T2_CAP_LOW, 8'h34);
      wr(`ADDR_T2_CAP_HIGH, 8'h12);
      wr(`ADDR_T2_HIGH, 8'hff);
      wr(`ADDR_T2_LOW, 8'hfe);
      wr(`ADDR_T2_CTRL, 8'h04);
      wr(`ADDR_T2_CTRL, 8'h00);
      check("tf2 set", tf2, 8'h01);
      core_model_i.rd(`ADDR_T2_HIGH, v);
      check("t2 high reload", v, 8'h12);
      wr(`ADDR_T2_CTRL, 8'h00);
      check("tf2 cleared", tf2, 8'h00);
      wr(`ADDR_T2_HIGH, 8'hff);
      // Overflow lands one edge after start, clear of the stop write
      wr(`ADDR_T2_LOW, 8'hff);
      wr(`ADDR_T2_CTRL, 8'h15);
      @(negedge clk_i);
      check("tf2 reserved", tf2, 8'h00);
      wr(`ADDR_T2_CTRL, 8'h00);
      core_model_i.rd(`ADDR_T2_HIGH, v);
      check("t2 reserved reload", v, 8'h12);
      wr(`ADDR_T2_LOW, 8'h00);
      wr(`ADDR_T2_HIGH, 8'h00);
      wr(`ADDR_T2_CTRL, 8'h06);
      pulses(1'b1, 3);
      wr(`ADDR_T2_CTRL, 8'h00);
      core_model_i.rd(`ADDR_T2_LOW, v);
      check("t2 pin count", v, 8'h03);
      repeat (5) @(posedge clk_i);
      core_model_i.rd(`ADDR_T2_LOW, v);
      check("t2 stopped", v, 8'h03);
      $display("third timer reload done");
   endtask
   task automatic t2_capture;
      wr(`ADDR_T2_CTRL, 8'h01);
      wr(`ADDR_T2_HIGH, 8'hab);
      wr(`ADDR_T2_LOW, 8'hcd);
      pulses(1'b0, 1);
      check("third_timer_external_flag ignored", third_timer_external_flag, 8'h00);
      core_model_i.rd(`ADDR_T2_CAP_LOW, v);
      check("cap low kept", v, 8'h34);
      wr(`ADDR_T2_CTRL, 8'h09);
      pulses(1'b0, 1);
      check("third_timer_external_flag capture", third_timer_external_flag, 8'h01);
      core_model_i.rd(`ADDR_T2_CAP_LOW, v);
      check("cap low", v, 8'hcd);
      core_model_i.rd(`ADDR_T2_CAP_HIGH, v);
      check("cap high", v, 8'hab);
      wr(`ADDR_T2_CTRL, 8'h08);
      check("third_timer_external_flag clear", third_timer_external_flag, 8'h00);
      wr(`ADDR_T2_HIGH, 8'h00);
      pulses(1'b0, 1);
      check("third_timer_external_flag reload", third_timer_external_flag, 8'h01);
      core_model_i.rd(`ADDR_T2_HIGH, v);
      check("trigger reload", v, 8'hab);
      wr(`ADDR_T2_CTRL, 8'h00);
      wr(`ADDR_T2_CTRL, 8'hc0);
      check("tf2 forced", tf2, 8'h01);
      check("third_timer_external_flag forced", third_timer_external_flag, 8'h01);
      $display("third timer capture done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_checks = 0;
      rst_i = 1'b1;
      trig = 1'b1;
      t2pin = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      basic_modes();
      split_mode();
      t2_reload();
      t2_capture();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      wrap_up();
   end
endmodule
